// ===== verilog/timer_chan_consts.vh
// Constants for one timer channel: register offsets, mode register
// fields, encodings and reset values.
// Assumes a plain register port with word offsets and 16-bit data.
`ifndef TIMER_CHAN_CONSTS_VH
`define TIMER_CHAN_CONSTS_VH

// Register offsets (word index)
`define OFS_MODE      3'h0
`define OFS_DATA      3'h1
`define OFS_CTRL      3'h2
`define OFS_COUNT     3'h3
`define OFS_STATUS    3'h4
`define OFS_MASK      3'h5

// Mode register fields
`define OPCLK_HI      15
`define OPCLK_LO      14
`define CCS_BIT       12
`define STS_HI        10
`define STS_LO        8
`define EDGE_HI       7
`define EDGE_LO       6
`define MD_HI         3
`define MD_LO         1
`define OPT_BIT       0
`define MODE_WMASK    16'hd7cf
`define MODE_RESET    16'h0000
`define DATA_RESET    16'h0000

// Start source encodings
`define STS_SOFT      3'h0
`define STS_EDGE      3'h1
`define STS_BOTH      3'h2
`define STS_MASTER    3'h4

// Operating mode encodings
`define MD_INTERVAL   3'h0
`define MD_CAPTURE    3'h2
`define MD_EVENT      3'h3
`define MD_ONECOUNT   3'h4
`define MD_CAPONE     3'h6

// Control register bits
`define CTRL_START    0
`define CTRL_STOP     1
`define CTRL_SLAVE    2
`define CTRL_RUN      4
`define CTRL_OUT      5

// Status and mask bits
`define ST_TIMER      0
`define ST_CFGERR     1
`define ST_WIDTH      2
`define ST_RESET      2'h0

`endif

// ===== verilog/edge_detect.v
// Input synchroniser and edge detector for the timer input pin.
// Assumes the pin is asynchronous; edges are judged only on sample ticks.
`timescale 1ns/1ps
module edge_detect (
  input  wire clock,
  input  wire rst_n,
  input  wire pin,
  input  wire sample_en,
  output wire rise,
  output wire fall
);
  reg sync1_q;
  reg sync2_q;
  reg last_q;

  // Two-flop synchroniser; the first flop feeds only the second
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= pin;
      sync2_q <= sync1_q;
    end
  end

  // Sample on the operating clock tick only, so glitches that fall
  // between two ticks are not seen
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      last_q <= 1'b0;
    end else if (sample_en) begin
      last_q <= sync2_q;
    end
  end

  assign rise = sample_en & sync2_q & ~last_q;
  assign fall = sample_en & ~sync2_q & last_q;
endmodule

// ===== verilog/timer_channel.v
// One timer channel with mode register, counter, output and interrupt.
// Assumes prescaler outputs and master interrupt are one-cycle pulses
// on the same clock; the timer input pin is asynchronous.
//
// Design decisions made here: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "timer_chan_consts.vh"
module timer_channel #(
  parameter CHANNEL = 5,
  parameter WIDTH   = 16
) (
  input  wire             clock,
  input  wire             rst_n,
  input  wire [2:0]       addr,
  input  wire [15:0]      wdata,
  input  wire             wr,
  input  wire             rd,
  output reg  [15:0]      rdata,
  input  wire             prescale_out0,
  input  wire             prescale_out1,
  input  wire             prescale_out2,
  input  wire             prescale_out3,
  input  wire             chan5_timer_input,
  input  wire             chan4_timer_irq,
  output reg              timer_irq,
  output reg              timer_out,
  output wire             irq
);
  localparam ST_IDLE = 1'b0;
  localparam ST_RUN  = 1'b1;
  localparam [WIDTH-1:0] ONE = {{(WIDTH-1){1'b0}}, 1'b1};
  localparam [WIDTH-1:0] ZERO = {WIDTH{1'b0}};
  localparam HAS_FAST = (CHANNEL == 1) || (CHANNEL == 3);

  reg  [15:0]       channel5_mode_q;
  reg  [WIDTH-1:0]  data_q;
  reg  [WIDTH-1:0]  count_q;
  reg               state_q;
  reg               slave_q;
  reg  [`ST_WIDTH-1:0] status_q;
  reg  [`ST_WIDTH-1:0] mask_q;

  wire              opclk_select_hi = channel5_mode_q[`OPCLK_HI];
  wire              opclk_select_lo = channel5_mode_q[`OPCLK_LO];
  wire              count_clock_source = channel5_mode_q[`CCS_BIT];
  wire [2:0]        start_src = channel5_mode_q[`STS_HI:`STS_LO];
  wire [1:0]        edge_sel = channel5_mode_q[`EDGE_HI:`EDGE_LO];
  wire [2:0]        mode = channel5_mode_q[`MD_HI:`MD_LO];
  wire              mode_option_bit = channel5_mode_q[`OPT_BIT];

  reg               opclk_tick;
  wire              edge_rise;
  wire              edge_fall;
  wire              any_edge = edge_rise | edge_fall;
  reg               valid_edge;
  wire              count_tick;
  wire              sw_start;
  wire              sw_stop;
  reg               trig;
  wire              mode_ok;
  wire              sts_ok;
  wire              count_up;
  wire              is_event;
  wire              is_interval;
  wire              is_capture;
  wire              is_onecount;
  wire              is_capone;

  // Operating clock select; slow channels ignore the low select bit
  // so a prohibited choice falls back to outputs 0 and 1
  always @* begin
    case ({opclk_select_hi, opclk_select_lo & HAS_FAST[0]})
      2'b00:   opclk_tick = prescale_out0;
      2'b01:   opclk_tick = prescale_out2;
      2'b10:   opclk_tick = prescale_out1;
      2'b11:   opclk_tick = prescale_out3;
      default: opclk_tick = prescale_out0;
    endcase
  end

  edge_detect u_edge (
    .clock     (clock),
    .rst_n     (rst_n),
    .pin       (chan5_timer_input),
    .sample_en (opclk_tick),
    .rise      (edge_rise),
    .fall      (edge_fall)
  );

  // Valid edge: 00 falling, 01 rising, 1x both edges
  always @* begin
    case (edge_sel)
      2'b00:   valid_edge = edge_fall;
      2'b01:   valid_edge = edge_rise;
      default: valid_edge = any_edge;
    endcase
  end

  assign is_interval = (mode == `MD_INTERVAL);
  assign is_capture  = (mode == `MD_CAPTURE);
  assign is_event    = (mode == `MD_EVENT);
  assign is_onecount = (mode == `MD_ONECOUNT);
  assign is_capone   = (mode == `MD_CAPONE);
  assign count_up    = is_capture | is_capone;

  // Event counter always counts input edges
  assign count_tick = (count_clock_source | is_event) ?
                      valid_edge : opclk_tick;

  // Only listed encodings may start the channel
  assign mode_ok = is_interval | is_capture | is_event |
                   is_onecount | is_capone;
  assign sts_ok = (start_src == `STS_SOFT) | (start_src == `STS_EDGE) |
                  (start_src == `STS_BOTH) |
                  (start_src == `STS_MASTER);

  assign sw_start = wr & (addr == `OFS_CTRL) & wdata[`CTRL_START];
  assign sw_stop  = wr & (addr == `OFS_CTRL) & wdata[`CTRL_STOP];

  // Start trigger from the chosen source; software always valid
  always @* begin
    trig = sw_start;
    case (start_src)
      `STS_EDGE:   trig = sw_start | valid_edge;
      `STS_BOTH:   trig = sw_start | any_edge;
      `STS_MASTER: trig = sw_start | chan4_timer_irq;
      default:     trig = sw_start;
    endcase
  end

  reg              state_d;
  reg [WIDTH-1:0]  count_d;
  reg [WIDTH-1:0]  data_d;
  reg              fire;
  reg              start_fire;
  reg              cfg_err;

  // Channel sequencer; counting acts on the count tick, captures and retriggers on the trigger or pin edge
  always @* begin
    state_d    = state_q;
    count_d    = count_q;
    data_d     = data_q;
    fire       = 1'b0;
    start_fire = 1'b0;
    cfg_err    = 1'b0;
    if (wr && (addr == `OFS_DATA)) begin
      data_d = wdata[WIDTH-1:0];
    end
    case (state_q)
      ST_IDLE: begin
        if (trig && !sw_stop) begin
          if (!mode_ok || !sts_ok) begin
            cfg_err = 1'b1;
          end else begin
            state_d = ST_RUN;
            count_d = count_up ? ZERO : data_d;
            // Start interrupt only in interval and capture modes
            start_fire = mode_option_bit &
                         (is_interval | is_capture);
          end
        end
      end
      ST_RUN: begin
        if (sw_stop) begin
          state_d = ST_IDLE;
        end else if (is_onecount && trig) begin
          if (mode_option_bit) begin
            count_d = data_d;
            fire    = 1'b1;
          end
        end else if (is_capture && (trig && !sw_start)) begin
          data_d  = count_q; // Capture and restart
          count_d = ZERO;
          fire    = 1'b1;
        end else if (is_capone && (start_src == `STS_BOTH ? any_edge
                                   : valid_edge)) begin
          // Retriggers ignored; only the closing edge counts
          data_d  = count_q;
          fire    = 1'b1;
          state_d = ST_IDLE;
        end else if (count_tick) begin
          if (count_up) begin
            count_d = count_q + ONE;
          end else if (count_q == ZERO) begin
            fire = 1'b1;
            if (is_onecount) begin
              state_d = ST_IDLE;
            end else begin
              count_d = data_d;
            end
          end else begin
            count_d = count_q - ONE;
          end
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // Counter, data and state flops
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      count_q <= ZERO;
      data_q  <= `DATA_RESET;
    end else begin
      state_q <= state_d;
      count_q <= count_d;
      data_q  <= data_d;
    end
  end

  // Mode and control registers; fixed-zero bits never store
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      channel5_mode_q <= `MODE_RESET;
      slave_q         <= 1'b0;
      mask_q          <= `ST_RESET;
    end else if (wr) begin
      if (addr == `OFS_MODE) begin
        channel5_mode_q <= wdata & `MODE_WMASK;
      end
      if (addr == `OFS_CTRL) begin
        slave_q <= wdata[`CTRL_SLAVE];
      end
      if (addr == `OFS_MASK) begin
        mask_q <= wdata[`ST_WIDTH-1:0];
      end
    end
  end

  wire own_irq = fire | start_fire;

  // Interrupt pulse and channel output; in slave mode the own
  // interrupt resets the output and wins over a master set
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      timer_irq <= 1'b0;
      timer_out <= 1'b0;
    end else begin
      timer_irq <= own_irq;
      if (slave_q) begin
        if (own_irq) begin
          timer_out <= 1'b0;
        end else if (chan4_timer_irq) begin
          timer_out <= 1'b1;
        end
      end else if (own_irq) begin
        timer_out <= ~timer_out;
      end
    end
  end

  wire rd_status = rd & (addr == `OFS_STATUS);
  wire [`ST_WIDTH-1:0] st_set = {cfg_err, own_irq};

  // Sticky status cleared by read; a new event wins over the clear
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= `ST_RESET;
    end else begin
      status_q <= (rd_status ? {`ST_WIDTH{1'b0}} : status_q) | st_set;
    end
  end

  assign irq = |(status_q & mask_q);

  // Zero-extended copies for readback; a zero-width pad would be
  // illegal when WIDTH is the full 16 bits
  reg [15:0] data_ext;
  reg [15:0] count_ext;
  always @* begin
    data_ext                = 16'h0000;
    count_ext               = 16'h0000;
    data_ext[WIDTH-1:0]     = data_q;
    count_ext[WIDTH-1:0]    = count_q;
  end

  // Read data valid the cycle after the strobe; unmapped reads zero
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 16'h0000;
    end else if (rd) begin
      case (addr)
        `OFS_MODE:   rdata <= channel5_mode_q;
        `OFS_DATA:   rdata <= data_ext;
        `OFS_CTRL:   rdata <= {10'h000, timer_out, state_q, 1'b0,
                               slave_q, 2'h0};
        `OFS_COUNT:  rdata <= count_ext;
        `OFS_STATUS: rdata <= {{(16-`ST_WIDTH){1'b0}}, status_q};
        `OFS_MASK:   rdata <= {{(16-`ST_WIDTH){1'b0}}, mask_q};
        default:     rdata <= 16'h0000;
      endcase
    end else begin
      rdata <= 16'h0000;
    end
  end
endmodule

// ===== verif/master_model.sv
// Partner model: master channel interrupt and the timer input pin.
// Assumes the bench pulses go for one cycle and sets pin_lvl.
`timescale 1ns/1ps
module master_model (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic go,
  input  wire logic pin_lvl,
  output logic      master_irq,
  output logic      pin
);
  // Registered so both reach the channel just after an edge
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      master_irq <= 1'b0;
      pin <= 1'b0;
    end else begin
      master_irq <= go;
      pin <= pin_lvl;
    end
  end
endmodule

// ===== verif/timer_channel_asserts.sv
// Checker for the timer channel: bus, start, slave output, interrupt.
// Assumes it is bound to timer_channel and sees only its ports.
`timescale 1ns/1ps
`include "timer_chan_consts.vh"
module timer_channel_asserts #(
  parameter CHANNEL = 5,
  parameter WIDTH   = 16
) (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic [2:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [15:0] rdata,
  input wire logic        prescale_out0,
  input wire logic        prescale_out1,
  input wire logic        prescale_out2,
  input wire logic        prescale_out3,
  input wire logic        chan5_timer_input,
  input wire logic        chan4_timer_irq,
  input wire logic        timer_irq,
  input wire logic        timer_out,
  input wire logic        irq
);
  logic [15:0] m_q;
  logic [1:0]  k_q;
  logic        run_q;
  logic        sl_q;
  logic        bad;
  // Shadows of software writes; run_q misses hardware starts and self-stops, so it can err either way
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      m_q <= 16'h0;
      k_q <= 2'h0;
      run_q <= 1'b0;
      sl_q <= 1'b0;
    end else if (wr) begin
      if (addr == `OFS_MODE) m_q <= wdata & `MODE_WMASK;
      if (addr == `OFS_MASK) k_q <= wdata[1:0];
      if (addr == `OFS_CTRL) begin
        run_q <= (run_q | wdata[0]) & ~wdata[1];
        sl_q <= wdata[2];
      end
    end
  end
  // Prohibited mode or start source
  assign bad = (m_q[3:1] inside {3'h1, 3'h5, 3'h7}) ||
               (m_q[10:8] inside {3'h3, 3'h5, 3'h6, 3'h7});
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence idle_start;
    wr && addr == `OFS_CTRL && wdata[0] && !wdata[1] && !run_q;
  endsequence
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 16'h0)
    else $error("read data not zero outside read cycle");
  a_mode_readback: assert property (
    rd && addr == `OFS_MODE |=> (rdata & 16'hbfff) ==
    ($past(m_q) & 16'hbfff)) else $error("mode read back wrong");
  a_start_irq: assert property (
    idle_start ##0 (m_q[3:0] == 4'h1 && m_q[10:8] == 3'h0)
    |-> ##[1:2] timer_irq) else $error("no start interrupt");
  a_start_quiet: assert property (
    idle_start ##0 (m_q[3:0] == 4'h0 && m_q[10:8] == 3'h0)
    |=> !timer_irq && $stable(timer_out)) else $error("start not quiet");
  a_bad_refused: assert property (
    idle_start ##0 bad |=> !timer_irq [*3])
    else $error("prohibited setting started");
  a_slave_reset: assert property (
    sl_q && timer_irq |-> ##[0:1] !timer_out)
    else $error("own interrupt did not clear output");
  a_slave_set: assert property (
    sl_q && !wr && chan4_timer_irq |=> timer_out || timer_irq)
    else $error("master interrupt did not set output");
  a_irq_masked: assert property (k_q == 2'h0 |-> !irq)
    else $error("irq with all masked");
  a_irq_follows: assert property (timer_irq && k_q[0] |-> ##[0:1] irq)
    else $error("irq missing");
endmodule
bind timer_channel timer_channel_asserts #(.CHANNEL(CHANNEL),
  .WIDTH(WIDTH)) u_chk (.clock(clock), .rst_n(rst_n), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .prescale_out0(prescale_out0), .prescale_out1(prescale_out1),
  .prescale_out2(prescale_out2), .prescale_out3(prescale_out3),
  .chan5_timer_input(chan5_timer_input),
  .chan4_timer_irq(chan4_timer_irq), .timer_irq(timer_irq),
  .timer_out(timer_out), .irq(irq));

// ===== verif/timer_channel_mode_control_tb.sv
// Self-checking bench for one timer channel.
// Assumes prescaler ticks divide the clock by 2, 4, 3 and 6.
`timescale 1ns/1ps
`include "timer_chan_consts.vh"
module timer_channel_mode_control_tb;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic [2:0]  addr = 3'h0;
  logic [15:0] wdata = 16'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        go = 1'b0;
  logic        pin_lvl = 1'b0;
  logic [3:0]  pc = 4'h0;
  wire  [15:0] rdata;
  wire         mirq, pin, timer_irq, timer_out, irq;
  int          failures = 0;
  int          checked = 0;
  int          n;
  // Prescaler ticks from one counter so their phases stay fixed
  wire p0 = (pc % 4'd2) == 4'd0;
  wire p1 = (pc % 4'd4) == 4'd0;
  wire p2 = (pc % 4'd3) == 4'd0;
  wire p3 = (pc % 4'd6) == 4'd0;
  always #5 clock = ~clock;
  // Wraps at 12 so every divider lines up
  always @(posedge clock) begin
    pc <= (pc == 4'd11) ? 4'd0 : pc + 4'd1;
  end
  master_model i_master (.clock(clock), .rst_n(rst_n), .go(go),
    .pin_lvl(pin_lvl), .master_irq(mirq), .pin(pin));
  timer_channel #(.CHANNEL(5), .WIDTH(16)) i_dut (.clock(clock),
    .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .prescale_out0(p0), .prescale_out1(p1),
    .prescale_out2(p2), .prescale_out3(p3), .chan5_timer_input(pin),
    .chan4_timer_irq(mirq), .timer_irq(timer_irq),
    .timer_out(timer_out), .irq(irq));
  task finish_test;
    begin
      $display("checks %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task cmp(input string s, input logic [15:0] e, input logic [15:0] g);
    begin
      checked++;
      if (g !== e) begin
        failures++;
        $display("CHECK FAILED %s expected %h seen %h", s, e, g);
      end
    end
  endtask
  // Bus tasks end 1 ns past the edge so no strobe is set twice at once
  task wreg(input logic [2:0] a, input logic [15:0] d);
    begin
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
      #1;
    end
  endtask
  task rreg(input logic [2:0] a, input logic [15:0] e, input string s);
    begin
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1;
      cmp(s, e, rdata);
    end
  endtask
  task wirq(output int c);
    begin
      c = 0;
      do begin
        @(posedge clock);
        #1;
        c++;
      end while (timer_irq !== 1'b1 && c < 300);
      if (c >= 300) begin
        failures++;
        finish_test;
      end
    end
  endtask
  task t_regs;
    begin
      rreg(`OFS_MODE, 16'h0, "mode reset");
      rreg(`OFS_STATUS, 16'h0, "status reset");
      wreg(`OFS_MODE, 16'hbfff);
      rreg(`OFS_MODE, 16'h97cf, "mode fixed bits");
      rreg(3'h7, 16'h0, "unmapped");
      $display("test regs done");
    end
  endtask
  task t_bad;
    begin
      wreg(`OFS_MODE, 16'h0002);
      wreg(`OFS_CTRL, 16'h1);
      rreg(`OFS_STATUS, 16'h2, "bad mode");
      wreg(`OFS_MODE, 16'h0300);
      wreg(`OFS_CTRL, 16'h1);
      rreg(`OFS_STATUS, 16'h2, "bad source");
      wreg(`OFS_CTRL, 16'h2);
      $display("test bad done");
    end
  endtask
  task t_clock;
    begin
      wreg(`OFS_DATA, 16'h3);
      for (int s = 0; s < 4; s++) begin
        wreg(`OFS_MODE, {s[1:0], 13'h0, s[0]});
        wreg(`OFS_CTRL, 16'h1);
        wirq(n);
        wirq(n);
        wirq(n);
        cmp("period", s[1] ? 16'd16 : 16'd8, n[15:0]);
        wreg(`OFS_CTRL, 16'h2);
      end
      #1 cmp("irq masked", 16'h0, {15'h0, irq});
      wreg(`OFS_MASK, 16'h1);
      cmp("irq", 16'h1, {15'h0, irq});
      rreg(`OFS_STATUS, 16'h1, "status");
      cmp("irq cleared", 16'h0, {15'h0, irq});
      $display("test clock done");
    end
  endtask
  task t_one(input logic opt);
    begin
      wreg(`OFS_CTRL, 16'h4);
      wreg(`OFS_DATA, 16'd20);
      wreg(`OFS_MODE, {15'h0204, opt});
      go <= 1'b1;
      @(posedge clock);
      go <= 1'b0;
      repeat (4) @(posedge clock);
      #1 cmp("out set", 16'h1, {15'h0, timer_out});
      go <= 1'b1;
      @(posedge clock);
      go <= 1'b0;
      wirq(n);
      cmp("retrigger", {15'h0, opt}, {15'h0, n < 8});
      @(posedge clock);
      #1 cmp("out clear", 16'h0, {15'h0, timer_out});
      wreg(`OFS_CTRL, 16'h6);
      $display("test one count done");
    end
  endtask
  task t_edge;
    begin
      wreg(`OFS_MODE, 16'h020c);
      pin_lvl <= 1'b1;
      n = 0;
      repeat (12) begin
        @(posedge clock);
        #1 n += timer_irq;
      end
      cmp("no start irq", 16'h0, n[15:0]);
      pin_lvl <= 1'b0;
      wirq(n);
      cmp("closing edge", 16'h1, {15'h0, n < 12});
      $display("test edge done");
    end
  endtask
  // Event counter on rising pin edges: data 2 fires on the third edge
  task t_event;
    begin
      wreg(`OFS_DATA, 16'h2);
      wreg(`OFS_MODE, 16'h0046);
      wreg(`OFS_CTRL, 16'h1);
      n = 0;
      repeat (3) begin
        pin_lvl <= 1'b1;
        repeat (8) begin
          @(posedge clock);
          #1 n += timer_irq;
        end
        pin_lvl <= 1'b0;
        repeat (8) begin
          @(posedge clock);
          #1 n += timer_irq;
        end
      end
      cmp("event fires", 16'h1, n[15:0]);
      cmp("master toggle", 16'h1, {15'h0, timer_out});
      wreg(`OFS_CTRL, 16'h2);
      $display("test event done");
    end
  endtask
  initial begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    t_regs;
    t_bad;
    t_clock;
    t_one(1'b1);
    t_one(1'b0);
    t_edge;
    t_event;
    finish_test;
  end
endmodule
